// ===== inc/tpp_defines.svh
// Constants of the three-phase PWM core: offsets, field positions, counts.
// Assumes a 100 MHz master clock on i_clk.
`ifndef TPP_DEFINES_SVH
`define TPP_DEFINES_SVH

`define TPP_CLK_MHZ 100
// Waveform memory access time in ns, and the wait it needs in cycles
`define TPP_ROM_ACC_NS 450
`define TPP_ROM_ACC_CYC ((`TPP_ROM_ACC_NS * `TPP_CLK_MHZ + 999) / 1000)
`define TPP_SYNC_CYC 3

// Staging register offsets
`define TPP_STG_R0 2'h0
`define TPP_STG_R1 2'h1
`define TPP_STG_R2 2'h2
`define TPP_STG_COMMIT 2'h3

// Initialisation word {R2, R1, R0}
`define TPP_PDT_MSB 6
`define TPP_PDT_LSB 0
`define TPP_CFS_MSB 10
`define TPP_CFS_LSB 8
`define TPP_FRS_MSB 13
`define TPP_FRS_LSB 11
`define TPP_PDY_MSB 21
`define TPP_PDY_LSB 16
// Control word {R2, R1, R0}
`define TPP_PFS_MSB 11
`define TPP_PFS_LSB 0
`define TPP_OM_BIT 12
`define TPP_REV_BIT 13
`define TPP_HOLDN_BIT 14
`define TPP_AMP_MSB 23
`define TPP_AMP_LSB 16

`define TPP_INIT_RST 24'h000000
`define TPP_CTRL_RST 24'h000000

// Timing figures
`define TPP_PDY_MAX 7'h40
`define TPP_PDT_MAX 8'h80
`define TPP_PHASE_MOD 22'h180000
`define TPP_ANG_FULL 12'h600
`define TPP_ANG_HALF 11'h300
`define TPP_ANG_120 10'h200
`define TPP_ZPP_START 11'h400
`define TPP_ROM_HI 11'h400
`define TPP_GAIN_DIV 17'h000ff
`define TPP_LEV_MID 10'h080
`define TPP_LEV_TOP 9'h100

`endif

// ===== inc/tpp_pkg.sv
// Types shared by the three-phase PWM core files.
// Assumes nothing beyond a SystemVerilog compiler.
package tpp_pkg;
    typedef enum logic [1:0] {TPP_RS_IDLE, TPP_RS_WAIT} tpp_rom_state_e;
    typedef logic [23:0] tpp_word_t;
    typedef logic [10:0] tpp_angle_t;
    typedef logic [8:0] tpp_level_t;
endpackage

// ===== verilog/tpp_phase_shaper.sv
// One phase leg: minimum-width filter then rising-edge underlap.
// Assumes i_tick marks one 1/512 carrier step, one cycle wide.
module tpp_phase_shaper
    import tpp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_raw,
    input wire logic [7:0] i_pdt,
    input wire logic [6:0] i_pdy,
    output logic o_top,
    output logic o_bot
);
    logic del_q;
    logic [7:0] run_q;
    logic [6:0] dly_q;
    logic take;

    // Change accepted only once it has lasted the deletion time
    assign take = i_tick && (i_raw != del_q) && (run_q + 8'h01 >= i_pdt);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            del_q <= 1'b0;
            run_q <= 8'h00;
        end else if (i_raw == del_q) begin
            run_q <= 8'h00;
        end else if (take) begin
            del_q <= i_raw;
            run_q <= 8'h00;
        end else if (i_tick) begin
            run_q <= run_q + 8'h01;
        end
    end

    // Underlap counts from the filtered edge, so it follows deletion
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dly_q <= 7'h00;
        end else if (take) begin
            dly_q <= 7'h00;
        end else if (i_tick && dly_q < i_pdy) begin
            dly_q <= dly_q + 7'h01;
        end
    end

    // Both legs off until the delay ends: no shoot-through
    assign o_top = del_q && (dly_q >= i_pdy);
    assign o_bot = !del_q && (dly_q >= i_pdy);
endmodule

// ===== verilog/tpp_pwm_core.sv
// Three-phase PWM generator core with staging registers and trip latch.
// Assumes staging strobes come from logic on i_clk; fault pin is async.
// Summary of operation
// - Carrier equals master clock over 512 times n, n from carrier_freq_select.
// - Power frequency range is carrier over 384 times m from freq_range_select.
// - Rising edges of all outputs delayed by pdy carrier steps.
// - Pulses shorter than pdt carrier steps are deleted.
// - Delay follows deletion; shortest output pulse is deletion minus delay.
// - Power frequency is range times 12-bit select over 4096.
// - Overmodulation bit zero keeps amplitude in the normal span.
// - Rotation bit zero gives forward red-yellow-blue sequence.
// - output_hold_n high leaves outputs active; low forces them off.
// - Waveform samples scale by waveform_gain_word over 255.
// - High fault input sets trip latch, driving status and outputs low.
// - Trip latch stays set until a reset cycle.
// - Fault input shuts down without processor involvement.
// - fault_status_n is low while tripped, high otherwise.
// - During reset every PWM output is forced low.
// - During reset all counters clear, phase at red zero degrees.
// - Reset release with fault low clears trip; outputs stay off until output_hold_n is set high.
// - zero_phase_pulse runs at power frequency with 1:2 mark-space.
// - Forward: its falling edge marks red phase zero degrees.
// - Reverse: its rising edge marks red phase zero degrees.
// - All PWM timing derives from the master clock.
// - Delay code inverted: all ones gives 1, all zeros gives 64.
// - Deletion code inverted: all ones gives 1, all zeros gives 128.
// - Range codes 000 to 110 give m of 1 to 64.
// - Commit write moves staged R0 to R2 into the active word at once.
`include "tpp_defines.svh"
module tpp_pwm_core
    import tpp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_stg_wr,
    input wire logic [1:0] i_stg_addr,
    input wire logic [7:0] i_stg_data,
    input wire logic i_stg_init,
    input wire logic i_fault_force,
    input wire logic [3:0] i_wave_nibble,
    output logic [10:0] o_wave_addr,
    output logic o_red_top,
    output logic o_red_bot,
    output logic o_yel_top,
    output logic o_yel_bot,
    output logic o_blu_top,
    output logic o_blu_bot,
    output logic o_fault_status_n,
    output logic o_zero_phase_pulse
);
    localparam int ROM_WAIT = `TPP_ROM_ACC_CYC + `TPP_SYNC_CYC;

    function automatic logic [7:0] carr_div(input logic [2:0] code);
        carr_div = 8'h01 << code;
    endfunction

    function automatic logic [2:0] range_shift(input logic [2:0] code);
        range_shift = (code == 3'h7) ? 3'h6 : code;
    endfunction

    function automatic tpp_angle_t phase_ang(input tpp_angle_t a, input logic [1:0] k);
        logic [11:0] t;
        t = {1'b0, a} + `TPP_ANG_FULL - ({10'h000, k} * {2'h0, `TPP_ANG_120});
        if (t >= `TPP_ANG_FULL) begin
            t = t - `TPP_ANG_FULL;
        end
        phase_ang = t[10:0];
    endfunction

    function automatic logic [10:0] rom_addr(input tpp_angle_t a, input logic [2:0] idx);
        tpp_angle_t p;
        tpp_angle_t s;
        p = phase_ang(a, idx[2:1]);
        s = (p >= `TPP_ANG_HALF) ? p - `TPP_ANG_HALF : p;
        rom_addr = idx[0] ? s + `TPP_ROM_HI : s;
    endfunction

    function automatic tpp_level_t lev_calc(input logic [7:0] smp, input logic neg,
                                            input logic [8:0] gain);
        logic [16:0] sc;
        logic [9:0] half;
        sc = ({9'h000, smp} * {8'h00, gain}) / `TPP_GAIN_DIV;
        half = sc[10:1];
        if (half >= `TPP_LEV_MID) begin
            lev_calc = neg ? 9'h000 : `TPP_LEV_TOP;
        end else if (neg) begin
            lev_calc = 9'(`TPP_LEV_MID - half);
        end else begin
            lev_calc = 9'(`TPP_LEV_MID + half);
        end
    endfunction

    // Staging and active parameter words
    logic [7:0] stg_q [3];
    tpp_word_t init_q;
    tpp_word_t ctrl_q;
    logic commit;

    assign commit = i_stg_wr && (i_stg_addr == `TPP_STG_COMMIT);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stg_q[0] <= 8'h00;
            stg_q[1] <= 8'h00;
            stg_q[2] <= 8'h00;
        end else if (i_stg_wr && !commit) begin
            stg_q[i_stg_addr] <= i_stg_data;
        end
    end

    // One-cycle copy keeps a half-updated word from ever reaching the engine
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            init_q <= `TPP_INIT_RST;
            ctrl_q <= `TPP_CTRL_RST;
        end else if (commit && i_stg_init) begin
            init_q <= {stg_q[2], stg_q[1], stg_q[0]};
        end else if (commit) begin
            ctrl_q <= {stg_q[2], stg_q[1], stg_q[0]};
        end
    end

    logic [2:0] carrier_freq_select;
    logic [2:0] freq_range_select;
    logic [7:0] pdt;
    logic [6:0] pdy;
    logic [11:0] pfs;
    logic [8:0] gain;
    logic rev;
    logic hold_n;

    assign carrier_freq_select = init_q[`TPP_CFS_MSB:`TPP_CFS_LSB];
    assign freq_range_select = init_q[`TPP_FRS_MSB:`TPP_FRS_LSB];
    assign pdt = `TPP_PDT_MAX - {1'b0, init_q[`TPP_PDT_MSB:`TPP_PDT_LSB]};
    assign pdy = `TPP_PDY_MAX - {1'b0, init_q[`TPP_PDY_MSB:`TPP_PDY_LSB]};
    assign pfs = ctrl_q[`TPP_PFS_MSB:`TPP_PFS_LSB];
    // Overmodulation acts as the ninth gain bit
    assign gain = {ctrl_q[`TPP_OM_BIT], ctrl_q[`TPP_AMP_MSB:`TPP_AMP_LSB]};
    assign rev = ctrl_q[`TPP_REV_BIT];
    assign hold_n = ctrl_q[`TPP_HOLDN_BIT];

    // Carrier: one tick every n clocks, 512 ticks per period
    logic [6:0] div_q;
    logic [8:0] pos_q;
    logic tick;
    logic cstart;

    assign tick = ({1'b0, div_q} + 8'h01 >= carr_div(carrier_freq_select));
    assign cstart = tick && (pos_q == 9'h1ff);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_q <= 7'h00;
            pos_q <= 9'h000;
        end else if (tick) begin
            div_q <= 7'h00;
            pos_q <= pos_q + 9'h001;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // Phase accumulator: one turn is 384 * 4096 units, 1024 per angle step
    logic [20:0] acc_q;
    logic [17:0] inc;
    logic [21:0] fwd;
    logic [21:0] bwd;
    tpp_angle_t ang;

    assign inc = {6'h00, pfs} << range_shift(freq_range_select);
    assign fwd = {1'b0, acc_q} + {4'h0, inc};
    assign bwd = {1'b0, acc_q} + `TPP_PHASE_MOD - {4'h0, inc};
    assign ang = acc_q[20:10];

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            acc_q <= 21'h000000;
        end else if (cstart && !rev) begin
            acc_q <= (fwd >= `TPP_PHASE_MOD) ? 21'(fwd - `TPP_PHASE_MOD) : fwd[20:0];
        end else if (cstart) begin
            acc_q <= (bwd >= `TPP_PHASE_MOD) ? 21'(bwd - `TPP_PHASE_MOD) : bwd[20:0];
        end
    end

    // High over the last third of the turn: the 0 degree crossing is the
    // falling edge going forward and the rising edge going backward
    logic zpp_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            zpp_q <= 1'b0;
        end else begin
            zpp_q <= (ang >= `TPP_ZPP_START);
        end
    end

    // Waveform memory: nibble data comes from a pin, so it is synchronised
    logic [3:0] nib1_q;
    logic [3:0] nib2_q;
    logic [3:0] nib3_q;

    always_ff @(posedge i_clk) begin
        nib1_q <= i_wave_nibble;
        nib2_q <= nib1_q;
        nib3_q <= nib2_q;
    end

    // Six reads a period: low then high nibble for each phase
    tpp_rom_state_e rs_q;
    logic [2:0] rd_q;
    logic [6:0] wt_q;
    tpp_angle_t snap_q;
    logic [10:0] addr_q;
    logic [7:0] smp_q [3];
    logic [2:0] neg_q;
    logic grab;

    assign grab = (rs_q == TPP_RS_WAIT) && (wt_q >= 7'(ROM_WAIT))
                  && (nib2_q == nib3_q);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rs_q <= TPP_RS_IDLE;
            rd_q <= 3'h0;
            wt_q <= 7'h00;
            snap_q <= 11'h000;
            addr_q <= 11'h000;
        end else if (cstart) begin
            rs_q <= TPP_RS_WAIT;
            rd_q <= 3'h0;
            wt_q <= 7'h00;
            snap_q <= ang;
            addr_q <= rom_addr(ang, 3'h0);
        end else begin
            case (rs_q)
                TPP_RS_IDLE: begin
                    wt_q <= 7'h00;
                end
                TPP_RS_WAIT: begin
                    if (grab) begin
                        rd_q <= rd_q + 3'h1;
                        wt_q <= 7'h00;
                        addr_q <= rom_addr(snap_q, rd_q + 3'h1);
                        if (rd_q == 3'h5) begin
                            rs_q <= TPP_RS_IDLE;
                        end
                    end else begin
                        wt_q <= wt_q + 7'h01;
                    end
                end
                default: begin
                    rs_q <= TPP_RS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            smp_q[0] <= 8'h00;
            smp_q[1] <= 8'h00;
            smp_q[2] <= 8'h00;
            neg_q <= 3'h0;
        end else if (grab && rd_q[0]) begin
            smp_q[rd_q[2:1]][7:4] <= nib3_q;
        end else if (grab) begin
            smp_q[rd_q[2:1]][3:0] <= nib3_q;
            neg_q[rd_q[2:1]] <= (phase_ang(snap_q, rd_q[2:1]) >= `TPP_ANG_HALF);
        end
    end

    // Regular sampling: levels from last period take effect at period start
    logic [7:0] tri_w;
    logic [2:0] top;
    logic [2:0] bot;
    tpp_level_t lev_q [3];

    assign tri_w = pos_q[8] ? ~pos_q[7:0] : pos_q[7:0];

    for (genvar k = 0; k < 3; k++) begin : g_phase
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                lev_q[k] <= 9'h000;
            end else if (cstart) begin
                lev_q[k] <= lev_calc(smp_q[k], neg_q[k], gain);
            end
        end

        tpp_phase_shaper u_shaper (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_tick(tick),
            .i_raw({1'b0, tri_w} < lev_q[k]),
            .i_pdt(pdt),
            .i_pdy(pdy),
            .o_top(top[k]),
            .o_bot(bot[k])
        );
    end

    // Fault pin: three stages, level moves once stages two and three agree
    logic flt1_q;
    logic flt2_q;
    logic flt3_q;
    logic fault_q;
    logic rst_q;
    logic trip_q;
    logic trip_d;
    logic stat_q;

    always_ff @(posedge i_clk) begin
        flt1_q <= i_fault_force;
        flt2_q <= flt1_q;
        flt3_q <= flt2_q;
        if (flt2_q == flt3_q) begin
            fault_q <= flt3_q;
        end
    end

    always_ff @(posedge i_clk) begin
        rst_q <= i_reset;
    end

    // Set wins over the release clear; nothing on the staging side can clear
    always_comb begin
        if (fault_q) begin
            trip_d = 1'b1;
        end else if (i_reset || rst_q) begin
            trip_d = 1'b0;
        end else begin
            trip_d = trip_q;
        end
    end

    always_ff @(posedge i_clk) begin
        trip_q <= trip_d;
        stat_q <= !trip_d;
    end

    logic [5:0] pwm_q;

    always_ff @(posedge i_clk) begin
        if (i_reset || trip_d || !hold_n) begin
            pwm_q <= 6'h00;
        end else begin
            pwm_q <= {bot[2], top[2], bot[1], top[1], bot[0], top[0]};
        end
    end

    assign o_red_top = pwm_q[0];
    assign o_red_bot = pwm_q[1];
    assign o_yel_top = pwm_q[2];
    assign o_yel_bot = pwm_q[3];
    assign o_blu_top = pwm_q[4];
    assign o_blu_bot = pwm_q[5];
    assign o_fault_status_n = stat_q;
    assign o_zero_phase_pulse = zpp_q;
    assign o_wave_addr = addr_q;

    // Carrier gap counter, only read by the checks below
    logic [7:0] gap_q;
    logic cfg_ok_q;

    always_ff @(posedge i_clk) begin
        if (i_reset || tick) begin
            gap_q <= 8'h00;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
        if (i_reset || (commit && i_stg_init)) begin
            cfg_ok_q <= 1'b0;
        end else if (tick) begin
            cfg_ok_q <= 1'b1;
        end
    end

    sequence s_release;
        i_reset ##1 (!i_reset && !fault_q);
    endsequence

    sequence s_commit_ctrl;
        i_stg_wr && (i_stg_addr == `TPP_STG_COMMIT) && !i_stg_init;
    endsequence

    a_carrier_gap: assert property (@(posedge i_clk) disable iff (i_reset)
        (tick && cfg_ok_q && !$past(commit)) |-> (gap_q + 8'h01 == carr_div(carrier_freq_select)))
        else $error("carrier step spacing differs from divider");
    a_trip_set: assert property (@(posedge i_clk)
        fault_q |=> (trip_q && !o_fault_status_n && pwm_q == 6'h00))
        else $error("fault did not trip outputs");
    a_trip_holds: assert property (@(posedge i_clk)
        (trip_q && !i_reset && !rst_q) |=> trip_q)
        else $error("trip latch cleared without reset");
    a_status_track: assert property (@(posedge i_clk) disable iff (i_reset)
        o_fault_status_n == !trip_q)
        else $error("status pin disagrees with trip latch");
    a_reset_off: assert property (@(posedge i_clk)
        i_reset |=> (pwm_q == 6'h00))
        else $error("outputs active during reset");
    a_reset_clear: assert property (@(posedge i_clk)
        i_reset [*2] |-> (acc_q == 21'h0 && pos_q == 9'h0 && div_q == 7'h0))
        else $error("counters not cleared in reset");
    a_release_clr: assert property (@(posedge i_clk)
        s_release |=> (!trip_q && o_fault_status_n))
        else $error("release did not clear trip");
    a_hold_off: assert property (@(posedge i_clk) disable iff (i_reset)
        !hold_n |=> (pwm_q == 6'h00))
        else $error("outputs active while held");
    a_commit_copy: assert property (@(posedge i_clk) disable iff (i_reset)
        s_commit_ctrl |=> (ctrl_q == {$past(stg_q[2]), $past(stg_q[1]), $past(stg_q[0])}))
        else $error("commit did not copy staged bytes");
    a_zpp_fwd: assert property (@(posedge i_clk) disable iff (i_reset)
        ($fell(zpp_q) && !rev) |-> ($past(ang) < `TPP_ANG_120))
        else $error("forward marker fell away from zero");
endmodule

// ===== bench/tpp_wave_rom.sv
// Waveform memory model standing at the far side of the PWM core.
// Assumes the core wants data combinationally from its address lines.
module tpp_wave_rom (
    input wire logic [10:0] i_addr,
    output logic [3:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sample 0 reads 0x55, so a halted angle still gives a known nonzero level
    always_comb begin
        if (i_addr[9:0] == 10'h000) begin
            o_data = 4'h5;
        end else if (i_addr[9:0] < 10'h300) begin
            o_data = i_addr[3:0] ^ i_addr[7:4];
        end else begin
            o_data = ~i_addr[3:0];
        end
    end
endmodule

// ===== bench/three_phase_pwm_params_and_trip_bench.sv
// Self-checking bench for the three-phase PWM core and its trip latch.
// Assumes the core and the waveform memory model are compiled before it.
module three_phase_pwm_params_and_trip_bench
    import tpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_stg_wr = 1'b0;
    logic [1:0] i_stg_addr = 2'h0;
    logic [7:0] i_stg_data = 8'h00;
    logic i_stg_init = 1'b0;
    logic i_fault_force = 1'b0;
    logic [3:0] nib;
    logic [10:0] waddr;
    logic rt, rb, yt, yb, bt, bb, stn, zero_phase_pulse;
    logic [5:0] outs;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rng = 32'd98;
    int exp_q[$];

    assign outs = {rt, rb, yt, yb, bt, bb};

    tpp_pwm_core i_tpp_pwm_core (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_stg_wr(i_stg_wr),
        .i_stg_addr(i_stg_addr),
        .i_stg_data(i_stg_data),
        .i_stg_init(i_stg_init),
        .i_fault_force(i_fault_force),
        .i_wave_nibble(nib),
        .o_wave_addr(waddr),
        .o_red_top(rt),
        .o_red_bot(rb),
        .o_yel_top(yt),
        .o_yel_bot(yb),
        .o_blu_top(bt),
        .o_blu_bot(bb),
        .o_fault_status_n(stn),
        .o_zero_phase_pulse(zero_phase_pulse)
    );

    tpp_wave_rom i_tpp_wave_rom (
        .i_addr(waddr),
        .o_data(nib)
    );

    always #5 i_clk = ~i_clk;

    task final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run is well under this; a hang ends here
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 100000) begin
            bad_count++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end

    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic sel(int k);
        case (k)
            0: return rt;
            1: return rb;
            2: return zero_phase_pulse;
            default: return stn;
        endcase
    endfunction

    // Cycles until the chosen output shows v, or -1 when the limit runs out
    task wait_lvl(input int k, input logic v, input int lim, output int t);
        t = -1;
        for (int i = 1; i <= lim; i++) begin
            @(posedge i_clk);
            #1;
            if (sel(k) === v) begin
                t = i;
                break;
            end
        end
    endtask

    always @(posedge i_clk) begin
        #1;
        check({rt & rb, yt & yb, bt & bb}, 3'h0);
    end

    // Carrier byte first, then delay, then deletion, then commit
    task prog(input logic init, input logic [7:0] r0, input logic [7:0] r1,
              input logic [7:0] r2);
        logic [1:0] a[4];
        logic [7:0] d[4];
        a = '{2'h1, 2'h2, 2'h0, 2'h3};
        d = '{r1, r2, r0, 8'h00};
        for (int i = 0; i < 4; i++) begin
            @(negedge i_clk);
            i_stg_wr = 1'b1;
            i_stg_addr = a[i];
            i_stg_data = d[i];
            i_stg_init = init;
        end
        @(negedge i_clk);
        i_stg_wr = 1'b0;
    endtask

    task do_reset();
        @(negedge i_clk);
        i_reset = 1'b1;
        repeat (3) @(negedge i_clk);
        check(outs, 6'h00);
        check(zero_phase_pulse, 1'b0);
        check(waddr, 11'h000);
        i_reset = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask

    initial begin
        int t0, t1, t2, t3, hi, lev;
        logic [5:0] pc[3];
        logic [31:0] r;
        pc = '{6'h3f, 6'h30, 6'h20};
        // Carrier period and rising-edge delay over three dividers
        for (int k = 0; k < 3; k++) begin
            do_reset();
            check(stn, 1'b1);
            prog(1'b1, 8'h00, k[7:0], {2'h0, pc[k]});
            prog(1'b0, 8'h00, 8'h40, 8'h00);
            repeat (1200 << k) @(negedge i_clk);
            wait_lvl(0, 1'b0, 5000, t0);
            wait_lvl(0, 1'b1, 5000, t0);
            wait_lvl(0, 1'b0, 5000, t1);
            wait_lvl(1, 1'b1, 5000, t2);
            check(t2, (64 - pc[k]) << k);
            wait_lvl(0, 1'b1, 5000, t3);
            check(t1 + t2 + t3, 512 << k);
        end
        $display("test carrier and delay done");
        // Output hold low keeps drives off; high lets them run
        do_reset();
        prog(1'b1, 8'h00, 8'h00, 8'h3f);
        prog(1'b0, 8'h00, 8'h00, 8'h00);
        wait_lvl(0, 1'b1, 1100, t1);
        check(t1, -1);
        prog(1'b0, 8'h00, 8'h40, 8'h00);
        wait_lvl(0, 1'b1, 1100, t1);
        check(t1 > 0, 1'b1);
        $display("test output hold done");
        // Fault pin trips, writes cannot clear it, reset with pin low does
        @(negedge i_clk);
        i_fault_force = 1'b1;
        wait_lvl(3, 1'b0, 10, t1);
        check(t1 > 0, 1'b1);
        check(outs, 6'h00);
        r = xs();
        prog(1'b0, r[7:0], r[15:8] | 8'h40, r[23:16]);
        repeat (600) @(negedge i_clk);
        check({stn, outs}, 7'h00);
        do_reset();
        check(stn, 1'b0);
        i_fault_force = 1'b0;
        repeat (6) @(negedge i_clk);
        do_reset();
        check(stn, 1'b1);
        prog(1'b1, 8'h00, 8'h00, 8'h3f);
        prog(1'b0, 8'h00, 8'h40, 8'h00);
        wait_lvl(0, 1'b1, 1100, t1);
        check(t1 > 0, 1'b1);
        $display("test trip latch done");
        // Amplitude: angle held at zero, red sample 0x55 from the memory model
        for (int om = 0; om < 2; om++) begin
            do_reset();
            r = xs();
            prog(1'b1, 8'h7f, 8'h00, 8'h3f);
            prog(1'b0, 8'h00, om ? 8'h50 : 8'h40, r[7:0]);
            lev = 128 + ((8'h55 * (om * 256 + r[7:0])) / 255) / 2;
            repeat (1600) @(negedge i_clk);
            wait_lvl(1, 1'b0, 600, t0);
            wait_lvl(1, 1'b1, 600, t0);
            wait_lvl(1, 1'b0, 600, t1);
            // Bottom leg spans the part of the triangle above the level, less one delay step
            check(t1, 512 - 2 * lev - 1);
        end
        $display("test amplitude done");
        // Zero phase pulse in both directions; 1536 steps over 384*4096
        for (int rev = 0; rev < 2; rev++) begin
            do_reset();
            prog(1'b1, 8'h7f, 8'h30, 8'h3f);
            prog(1'b0, 8'h00, rev ? 8'h68 : 8'h48, 8'h00);
            hi = (1572864 / (2048 << 6)) / 3 * 512;
            exp_q.push_back(hi);
            exp_q.push_back(2 * hi);
            wait_lvl(2, 1'b1, 6000, t0);
            wait_lvl(2, 1'b0, 5000, t1);
            wait_lvl(2, 1'b1, 6000, t2);
            check(t1, exp_q.pop_front());
            check(t2, exp_q.pop_front());
            if (rev == 0)
                check(t0 >= 7 * 512 && t0 <= 9 * 512, 1'b1);
            else
                check(t0 > 0 && t0 <= 2 * 512, 1'b1);
        end
        $display("test zero phase pulse done");
        final_report();
    end
endmodule
